// file: core/bps_sequencer.sv
// Overview of operation
// - Outputs toward the processor stay low until the unlock step.
// - Every sequenced rail has its own enable output.
// - Auxiliary 3.3 V rail enabled at once on main power start.
// - Support 1.2 V enabled after aux 3.3 V stable 5 ms.
// - 2.5 V rail enabled after support 1.2 V stable 5 ms.
// - After 2.5 V stable 15 ms, adaptive core rail enabled first.
// - Fixed DSP and ARM core rails follow after 5 ms.
// - Then 0.85 V, proc 3.3 V, 1.8 V, 1.5 V DDR, 5 ms apart.
// - Both DDR termination rails enabled together after DDR 5 ms.
// - USB 5 V enabled after both termination rails stable 5 ms.
// - After 5 V stable 5 ms unlock outputs, release clock PD pins.
// - Warm reset, NMI released after supplies and PLLs good 5 ms.
// - Boot configuration driven on GPIO while resets are released.
// - Power-on reset released 5 ms after warm reset.
// - Full reset released 5 ms after power-on reset.
// - Boot pins released 1 ms after full reset release.
// - Power failure or payload loss asserts full and power-on reset.
// - 5 ms later lock outputs low and stop clock generators.
// - Finally all sequenced rails switched off together.
`timescale 1ns/1ns
module bps_sequencer #(
  parameter int STEP_CYC =
    bps_pkg::T_STEP_US * (bps_pkg::CLK_HZ / bps_pkg::US_PER_S),
  parameter int CORE_CYC =
    bps_pkg::T_CORE_US * (bps_pkg::CLK_HZ / bps_pkg::US_PER_S),
  parameter int BOOT_CYC =
    bps_pkg::T_BOOT_US * (bps_pkg::CLK_HZ / bps_pkg::US_PER_S),
  parameter int CNT_W    = 19
) (
  // Clock, reset, enable
  input  wire logic                           mclk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  // Supply status
  input  wire logic                           payloadGood,
  input  wire logic                           powerFail,
  input  wire logic [bps_pkg::NUM_RAILS-1:0]  railPowerGood,
  input  wire logic                           procSupplyGood,
  input  wire logic [bps_pkg::NUM_CLKGEN-1:0] pllLocked,
  // Rail enables
  output logic      [bps_pkg::NUM_RAILS-1:0]  railEnable,
  // Clock generators
  output logic      [bps_pkg::NUM_CLKGEN-1:0] clkgenPowerdownN,
  // Processor pins
  output bps_pkg::bps_proc_rst_t              procReset,
  output logic                                procNmiN,
  output logic                                outputsUnlocked,
  // Boot configuration pins
  input  wire logic [bps_pkg::BOOT_W-1:0]     bootCfgValue,
  output logic      [bps_pkg::BOOT_W-1:0]     bootCfgOut,
  output logic                                bootCfgOeN
);

  bps_pkg::bps_state_t           stateReg;
  bps_pkg::bps_state_t           stateNext;
  logic [CNT_W-1:0]              cntReg;
  logic [bps_pkg::NUM_RAILS-1:0] seenReg;
  logic                          stepCond;
  logic                          stepDone;
  logic                          railFault;
  logic                          failEv;
  logic                          failGo;

  // Rails switched on in, and watched by, each wait state
  function automatic logic [bps_pkg::NUM_RAILS-1:0] railsOf(
    input bps_pkg::bps_state_t s);
    logic [bps_pkg::NUM_RAILS-1:0] m;
    m = bps_pkg::RAILS_OFF;
    case (s)
      bps_pkg::S_AUX:  m[bps_pkg::RAIL_AUX] = 1'b1;
      bps_pkg::S_SUP:  m[bps_pkg::RAIL_SUP] = 1'b1;
      bps_pkg::S_PHY:  m[bps_pkg::RAIL_PHY] = 1'b1;
      bps_pkg::S_CORE: m[bps_pkg::RAIL_ADAPT] = 1'b1;
      bps_pkg::S_FIX: begin
        m[bps_pkg::RAIL_DSP] = 1'b1;
        m[bps_pkg::RAIL_ARM] = 1'b1;
      end
      bps_pkg::S_SER:  m[bps_pkg::RAIL_SERDES] = 1'b1;
      bps_pkg::S_P33:  m[bps_pkg::RAIL_P33] = 1'b1;
      bps_pkg::S_IO:   m[bps_pkg::RAIL_IO] = 1'b1;
      bps_pkg::S_DDR:  m[bps_pkg::RAIL_DDR] = 1'b1;
      bps_pkg::S_TERM: begin
        m[bps_pkg::RAIL_TERM_A] = 1'b1;
        m[bps_pkg::RAIL_TERM_B] = 1'b1;
      end
      bps_pkg::S_USB:  m[bps_pkg::RAIL_USB] = 1'b1;
      default:         m = bps_pkg::RAILS_OFF;
    endcase
    return m;
  endfunction

  // Wait length of each timed state
  function automatic logic [CNT_W-1:0] waitLen(
    input bps_pkg::bps_state_t s);
    logic [CNT_W-1:0] n;
    n = CNT_W'(STEP_CYC);
    case (s)
      bps_pkg::S_PHY:  n = CNT_W'(CORE_CYC);
      bps_pkg::S_FULL: n = CNT_W'(BOOT_CYC);
      default:         n = CNT_W'(STEP_CYC);
    endcase
    return n;
  endfunction

  // Successor in the power-up order
  function automatic bps_pkg::bps_state_t succ(
    input bps_pkg::bps_state_t s);
    bps_pkg::bps_state_t n;
    n = s;
    case (s)
      bps_pkg::S_AUX:  n = bps_pkg::S_SUP;
      bps_pkg::S_SUP:  n = bps_pkg::S_PHY;
      bps_pkg::S_PHY:  n = bps_pkg::S_CORE;
      bps_pkg::S_CORE: n = bps_pkg::S_FIX;
      bps_pkg::S_FIX:  n = bps_pkg::S_SER;
      bps_pkg::S_SER:  n = bps_pkg::S_P33;
      bps_pkg::S_P33:  n = bps_pkg::S_IO;
      bps_pkg::S_IO:   n = bps_pkg::S_DDR;
      bps_pkg::S_DDR:  n = bps_pkg::S_TERM;
      bps_pkg::S_TERM: n = bps_pkg::S_USB;
      bps_pkg::S_USB:  n = bps_pkg::S_PLL;
      bps_pkg::S_PLL:  n = bps_pkg::S_WARM;
      bps_pkg::S_WARM: n = bps_pkg::S_POR;
      bps_pkg::S_POR:  n = bps_pkg::S_FULL;
      bps_pkg::S_FULL: n = bps_pkg::S_RUN;
      default:         n = s;
    endcase
    return n;
  endfunction

  // Condition that must hold for the current wait
  always_comb begin
    stepCond = 1'b0;
    case (stateReg)
      bps_pkg::S_PLL:
        stepCond = procSupplyGood && (&pllLocked);
      bps_pkg::S_WARM, bps_pkg::S_POR, bps_pkg::S_FULL,
      bps_pkg::S_DNR:
        stepCond = 1'b1;
      default:
        stepCond = (railsOf(stateReg) != bps_pkg::RAILS_OFF) &&
                   (&(railPowerGood | ~railsOf(stateReg)));
    endcase
  end

  assign stepDone  = stepCond && (cntReg == waitLen(stateReg) - 1'b1);
  assign railFault = |(seenReg & ~railPowerGood);
  assign failEv    = powerFail || !payloadGood || railFault;
  assign failGo    = (stateNext == bps_pkg::S_DNR) &&
                     (stateReg != bps_pkg::S_DNR);

  // Sequence control
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      bps_pkg::S_OFF:
        if (payloadGood && !powerFail) begin
          stateNext = bps_pkg::S_AUX;
        end
      bps_pkg::S_DNR:
        if (stepDone) begin
          stateNext = bps_pkg::S_DNL;
        end
      bps_pkg::S_DNL:
        stateNext = bps_pkg::S_OFF;
      bps_pkg::S_RUN:
        if (failEv) begin
          stateNext = bps_pkg::S_DNR;
        end
      default:
        if (failEv) begin
          stateNext = bps_pkg::S_DNR;
        end else if (stepDone) begin
          stateNext = succ(stateReg);
        end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stateReg <= bps_pkg::S_OFF;
    end else if (ce) begin
      stateReg <= stateNext;
    end
  end

  // Stability counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      cntReg <= '0;
    end else if (ce) begin
      if (stateNext != stateReg || !stepCond) begin
        cntReg <= '0;
      end else if (!stepDone) begin
        cntReg <= cntReg + 1'b1;
      end
    end
  end

  // Rails already proven good
  always_ff @(posedge mclk) begin
    if (rst) begin
      seenReg <= bps_pkg::RAILS_OFF;
    end else if (ce) begin
      if (stateReg == bps_pkg::S_OFF || stateReg == bps_pkg::S_DNR ||
          stateReg == bps_pkg::S_DNL) begin
        seenReg <= bps_pkg::RAILS_OFF;
      end else if (stepDone) begin
        seenReg <= seenReg | railsOf(stateReg);
      end
    end
  end

  // Rail enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      railEnable <= bps_pkg::RAILS_OFF;
    end else if (ce) begin
      if (stateNext == bps_pkg::S_OFF) begin
        railEnable <= bps_pkg::RAILS_OFF;
      end else begin
        railEnable <= railEnable | railsOf(stateNext);
      end
    end
  end

  // Output lock and clock generator power-down
  always_ff @(posedge mclk) begin
    if (rst) begin
      outputsUnlocked  <= 1'b0;
      clkgenPowerdownN <= bps_pkg::CLKGEN_PD;
    end else if (ce) begin
      if (stateReg == bps_pkg::S_USB && stateNext == bps_pkg::S_PLL)
      begin
        outputsUnlocked  <= 1'b1;
        clkgenPowerdownN <= bps_pkg::CLKGEN_RUN;
      end else if (stateNext == bps_pkg::S_DNL) begin
        outputsUnlocked  <= 1'b0;
        clkgenPowerdownN <= bps_pkg::CLKGEN_PD;
      end
    end
  end

  // Processor resets and NMI
  always_ff @(posedge mclk) begin
    if (rst) begin
      procReset <= bps_pkg::RST_HELD;
      procNmiN  <= 1'b0;
    end else if (ce) begin
      if (stateNext == bps_pkg::S_DNL) begin
        procReset <= bps_pkg::RST_HELD;
        procNmiN  <= 1'b0;
      end else if (failGo) begin
        procReset.procPowerOnResetN <= 1'b0;
        procReset.procFullResetN    <= 1'b0;
      end else if (stepDone) begin
        case (stateReg)
          bps_pkg::S_PLL: begin
            procReset.procWarmResetN <= 1'b1;
            procNmiN                 <= 1'b1;
          end
          bps_pkg::S_WARM:
            procReset.procPowerOnResetN <= 1'b1;
          bps_pkg::S_POR:
            procReset.procFullResetN <= 1'b1;
          default: begin
          end
        endcase
      end
    end
  end

  // Boot configuration drive
  always_ff @(posedge mclk) begin
    if (rst) begin
      bootCfgOut <= bps_pkg::BOOT_IDLE;
      bootCfgOeN <= 1'b1;
    end else if (ce) begin
      if (failGo || (stateReg == bps_pkg::S_FULL && stepDone)) begin
        bootCfgOut <= bps_pkg::BOOT_IDLE;
        bootCfgOeN <= 1'b1;
      end else if (stateNext == bps_pkg::S_PLL &&
                   stateReg == bps_pkg::S_USB) begin
        bootCfgOut <= bootCfgValue;
        bootCfgOeN <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  locked_outputs_low_a: assert property (
    !outputsUnlocked |-> procReset == bps_pkg::RST_HELD && !procNmiN
      && clkgenPowerdownN == bps_pkg::CLKGEN_PD)
    else $error("processor outputs not held low while locked");

  aux_first_on_a: assert property (
    $rose(railEnable[bps_pkg::RAIL_AUX]) |->
      $past(railEnable) == bps_pkg::RAILS_OFF &&
      $past(payloadGood) && stateReg == bps_pkg::S_AUX)
    else $error("aux rail not first or not on payload start");

  support_after_aux_a: assert property (
    $rose(railEnable[bps_pkg::RAIL_SUP]) |->
      $past(cntReg) == CNT_W'(STEP_CYC - 1) &&
      $past(railPowerGood[bps_pkg::RAIL_AUX]))
    else $error("support rail enabled before aux stable interval");

  core_after_phy_a: assert property (
    $rose(railEnable[bps_pkg::RAIL_ADAPT]) |->
      $past(cntReg) == CNT_W'(CORE_CYC - 1) &&
      !railEnable[bps_pkg::RAIL_DSP])
    else $error("adaptive core rail timing wrong");

  term_rails_pair_a: assert property (
    railEnable[bps_pkg::RAIL_TERM_A] == railEnable[bps_pkg::RAIL_TERM_B])
    else $error("termination rails enabled apart");

  fail_resets_a: assert property (
    ce && failEv && stateReg != bps_pkg::S_OFF &&
    stateReg != bps_pkg::S_DNR && stateReg != bps_pkg::S_DNL |=>
      !procReset.procPowerOnResetN && !procReset.procFullResetN)
    else $error("resets not asserted on power failure");

  lock_then_off_a: assert property (
    ce && stateReg == bps_pkg::S_DNL |=>
      railEnable == bps_pkg::RAILS_OFF && !outputsUnlocked)
    else $error("rails not switched off after lock");

  count_restart_a: assert property (
    ce && !stepCond |=> cntReg == '0)
    else $error("stability counter not restarted");

  reset_order_a: assert property (
    $rose(procReset.procPowerOnResetN) |->
      procReset.procWarmResetN && $past(cntReg) == CNT_W'(STEP_CYC - 1))
    else $error("power-on reset released out of order");

  full_reset_order_a: assert property (
    $rose(procReset.procFullResetN) |->
      procReset.procPowerOnResetN && !bootCfgOeN)
    else $error("full reset released out of order");

  reach_run_c: cover property (stateReg == bps_pkg::S_RUN);
  fail_in_run_c: cover property (
    stateReg == bps_pkg::S_RUN && failEv && ce);
  fault_mid_up_c: cover property (railFault && stateReg == bps_pkg::S_CORE);
  full_down_c: cover property (stateReg == bps_pkg::S_DNL);

endmodule

// file: core/bps_pkg.sv
package bps_pkg;

  // Sequencer clock and documented intervals
  localparam int CLK_HZ    = 20_000_000;
  localparam int US_PER_S  = 1_000_000;
  localparam int T_STEP_US = 5000;
  localparam int T_CORE_US = 15000;
  localparam int T_BOOT_US = 1000;

  // Sequenced rails, one enable and one power-good bit each
  localparam int NUM_RAILS   = 13;
  localparam int RAIL_AUX    = 0;
  localparam int RAIL_SUP    = 1;
  localparam int RAIL_PHY    = 2;
  localparam int RAIL_ADAPT  = 3;
  localparam int RAIL_DSP    = 4;
  localparam int RAIL_ARM    = 5;
  localparam int RAIL_SERDES = 6;
  localparam int RAIL_P33    = 7;
  localparam int RAIL_IO     = 8;
  localparam int RAIL_DDR    = 9;
  localparam int RAIL_TERM_A = 10;
  localparam int RAIL_TERM_B = 11;
  localparam int RAIL_USB    = 12;

  // Clock generators and boot pins
  localparam int NUM_CLKGEN = 3;
  localparam int BOOT_W     = 4;

  // Reset and run values
  localparam logic [NUM_RAILS-1:0]  RAILS_OFF   = 13'h0000;
  localparam logic [NUM_CLKGEN-1:0] CLKGEN_PD   = 3'h0;
  localparam logic [NUM_CLKGEN-1:0] CLKGEN_RUN  = 3'h7;
  localparam logic [BOOT_W-1:0]     BOOT_IDLE   = 4'h0;

  typedef enum logic [4:0] {
    S_OFF, S_AUX, S_SUP, S_PHY, S_CORE, S_FIX, S_SER, S_P33,
    S_IO, S_DDR, S_TERM, S_USB, S_PLL, S_WARM, S_POR, S_FULL,
    S_RUN, S_DNR, S_DNL
  } bps_state_t;

  // Processor reset pins, all active low
  typedef struct packed {
    logic procWarmResetN;
    logic procPowerOnResetN;
    logic procFullResetN;
  } bps_proc_rst_t;

  localparam bps_proc_rst_t RST_HELD = 3'h0;

endpackage

// file: dv/bps_rail_model.sv
`timescale 1ns/1ns
module bps_rail_model (
  // Clock
  input  wire logic                           mclk,
  // From sequencer
  input  wire logic [bps_pkg::NUM_RAILS-1:0]  railEnable,
  input  wire logic [bps_pkg::NUM_CLKGEN-1:0] clkgenPowerdownN,
  // Test controls
  input  wire logic [3:0]                     lag,
  input  wire logic [bps_pkg::NUM_RAILS-1:0]  dropMask,
  // Status back
  output logic      [bps_pkg::NUM_RAILS-1:0]  railPowerGood,
  output logic                                procSupplyGood,
  output logic      [bps_pkg::NUM_CLKGEN-1:0] pllLocked
);
  int railAge [bps_pkg::NUM_RAILS];
  int pllAge;

  // Regulator start delay, output collapses with its enable
  always_ff @(posedge mclk) begin
    for (int i = 0; i < bps_pkg::NUM_RAILS; i++) begin
      railAge[i] <= !railEnable[i] ? 0 :
                    (railAge[i] > lag) ? railAge[i] : railAge[i] + 1;
    end
    pllAge <= !(&clkgenPowerdownN) ? 0 :
              (pllAge > lag) ? pllAge : pllAge + 1;
  end

  // Good only while enabled, aged and not faulted
  always_comb begin
    for (int i = 0; i < bps_pkg::NUM_RAILS; i++) begin
      railPowerGood[i] = railEnable[i] && (railAge[i] > lag) && !dropMask[i];
    end
  end

  assign procSupplyGood = &railPowerGood;
  assign pllLocked      = {bps_pkg::NUM_CLKGEN{pllAge > lag}};
endmodule

// file: dv/bps_sequencer_test.sv
`timescale 1ns/1ns
module bps_sequencer_test;
  localparam int STEP  = 8;
  localparam int CORE  = 24;
  localparam int BOOT  = 4;
  localparam int SLACK = 20;
  typedef struct {
    logic [25:0] v;
    int          lo;
    int          hi;
  } bps_note_t;

  logic                  mclk        = 1'b0;
  logic                  rst         = 1'b1;
  logic                  ce          = 1'b1;
  logic                  payloadGood = 1'b0;
  logic                  powerFail   = 1'b0;
  logic [3:0]            lag         = 4'h0;
  logic [12:0]           dropMask    = 13'h0000;
  logic [3:0]            bootCfgValue = 4'h0;
  logic [12:0]           railPowerGood;
  logic                  procSupplyGood;
  logic [2:0]            pllLocked;
  logic [12:0]           railEnable;
  logic [2:0]            clkgenPowerdownN;
  bps_pkg::bps_proc_rst_t procReset;
  logic                  procNmiN;
  logic                  outputsUnlocked;
  logic [3:0]            bootCfgOut;
  logic                  bootCfgOeN;
  logic [25:0]           outs;
  logic [25:0]           prev;
  bps_note_t             q[$];
  bps_note_t             cur;
  int                    cyc;
  int                    lastCyc;
  int                    n_errors;
  int                    total_checks;

  assign outs = {railEnable, clkgenPowerdownN, procReset, procNmiN,
                 outputsUnlocked, bootCfgOeN, bootCfgOut};

  bps_sequencer #(.STEP_CYC(STEP), .CORE_CYC(CORE), .BOOT_CYC(BOOT)) uut (
    .mclk(mclk), .rst(rst), .ce(ce), .payloadGood(payloadGood),
    .powerFail(powerFail), .railPowerGood(railPowerGood),
    .procSupplyGood(procSupplyGood), .pllLocked(pllLocked),
    .railEnable(railEnable), .clkgenPowerdownN(clkgenPowerdownN),
    .procReset(procReset), .procNmiN(procNmiN),
    .outputsUnlocked(outputsUnlocked), .bootCfgValue(bootCfgValue),
    .bootCfgOut(bootCfgOut), .bootCfgOeN(bootCfgOeN));

  bps_rail_model partner (
    .mclk(mclk), .railEnable(railEnable),
    .clkgenPowerdownN(clkgenPowerdownN), .lag(lag), .dropMask(dropMask),
    .railPowerGood(railPowerGood), .procSupplyGood(procSupplyGood),
    .pllLocked(pllLocked));

  initial begin
    forever #25 mclk = ~mclk;
  end

  task automatic err(string msg);
    n_errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic chk_val(logic [25:0] got, logic [25:0] exp);
    total_checks++;
    if (got !== exp) err($sformatf("outputs %h expected %h", got, exp));
  endtask

  task automatic chk_gap(int got, int lo, int hi);
    total_checks++;
    if (got < lo || got > hi) err($sformatf("gap %0d not in %0d..%0d",
                                            got, lo, hi));
  endtask

  task automatic note(logic [25:0] v, int lo, int hi);
    q.push_back('{v, lo, hi});
  endtask

  task automatic wait_empty();
    for (int k = 0; k < 2000 && q.size() > 0; k++) @(negedge mclk);
    if (q.size() > 0) err("expected output change missing");
    q.delete();
  endtask

  // Watches outputs and checks each change against the oldest note
  always @(posedge mclk) begin
    #5;
    cyc++;
    if (!rst && outs !== prev) begin
      if (q.size() == 0) begin
        err("unexpected output change");
      end else begin
        cur = q.pop_front();
        chk_val(outs, cur.v);
        chk_gap(cyc - lastCyc, cur.lo, cur.hi);
      end
      lastCyc = cyc;
    end
    prev = outs;
  end

  task automatic power_up(int upto);
    logic [12:0] stage [11];
    int          w;
    int          hi;
    stage = '{13'h0001, 13'h0003, 13'h0007, 13'h000F, 13'h003F, 13'h007F,
              13'h00FF, 13'h01FF, 13'h03FF, 13'h0FFF, 13'h1FFF};
    bootCfgValue = 4'($urandom);
    lag = 4'($urandom_range(0, 7));
    for (int i = 0; i <= upto; i++) begin
      w = (i == 3) ? CORE : STEP;
      hi = w + SLACK;
      case (i)
        0: note({stage[0], 9'h001, 4'h0}, 1, 1);
        1, 2: note({stage[i], 9'h001, 4'h0}, w, hi);
        3: note({stage[i], 9'h001, 4'h0}, w, hi);
        4: note({stage[i], 9'h001, 4'h0}, w, hi);
        5, 6, 7, 8: note({stage[i], 9'h001, 4'h0}, w, hi);
        9: note({stage[i], 9'h001, 4'h0}, w, hi);
        10: note({stage[i], 9'h001, 4'h0}, w, hi);
        11: note({13'h1FFF, 9'h1C2, bootCfgValue}, w, hi);
        12: note({13'h1FFF, 9'h1E6, bootCfgValue}, w, hi);
        13: note({13'h1FFF, 9'h1F6, bootCfgValue}, STEP, STEP + 1);
        14: note({13'h1FFF, 9'h1FE, bootCfgValue}, STEP, STEP + 1);
        15: note({13'h1FFF, 9'h1FF, 4'h0}, BOOT, BOOT + 1);
        default: err("stage index out of range");
      endcase
    end
    @(negedge mclk);
    payloadGood = 1'b1;
    powerFail = 1'b0;
    lastCyc = cyc;
    wait_empty();
  endtask

  task automatic power_down(bit viaFail);
    note({13'h1FFF, 9'h1E7, 4'h0}, 1, 1);
    note({13'h1FFF, 9'h001, 4'h0}, STEP, STEP + 1);
    note({13'h0000, 9'h001, 4'h0}, 1, 1);
    @(negedge mclk);
    if (viaFail) powerFail = 1'b1;
    else payloadGood = 1'b0;
    lastCyc = cyc;
    wait_empty();
  endtask

  task automatic test_done();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h3f10));
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    chk_val(outs, {13'h0000, 9'h001, 4'h0});
    // Full power-up, payload loss while running
    power_up(15);
    power_down(1'b0);
    // Failure while boot pins are still driven
    power_up(13);
    power_down(1'b1);
    // Proven rail lost mid-sequence, then restart
    power_up(3);
    note({13'h0000, 9'h001, 4'h0}, 1, STEP + 3);
    note({13'h0001, 9'h001, 4'h0}, 1, STEP + 4);
    @(negedge mclk);
    dropMask = 13'h0001;
    lastCyc = cyc;
    wait_empty();
    // Good glitch restarts the stability count
    note({13'h0003, 9'h001, 4'h0}, STEP + 3, STEP + 6);
    dropMask = 13'h0000;
    repeat (STEP / 2) @(negedge mclk);
    dropMask = 13'h0001;
    @(negedge mclk);
    dropMask = 13'h0000;
    lastCyc = cyc;
    // Clock enable low freezes the count for three edges
    repeat (4) @(negedge mclk);
    ce = 1'b0;
    repeat (3) @(negedge mclk);
    ce = 1'b1;
    wait_empty();
    note({13'h0000, 9'h001, 4'h0}, STEP, STEP + 4);
    @(negedge mclk);
    payloadGood = 1'b0;
    lastCyc = cyc;
    wait_empty();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err("timeout");
    test_done();
  end
endmodule
